/* File: bench/rscc_top_assertions.sv */
/* port assertions of rscc_top.
   bound to rscc_top below; one clock domain. */
`timescale 1ns/1ns
`include "rscc_map.svh"
module rscc_chk (
  input wire logic                 i_mclk,
  input wire logic                 i_srst,
  input wire logic                 i_pin_rst,
  input wire logic                 i_wdt_rst,
  input wire logic                 i_bor_rst,
  input wire logic                 i_sfr_rd,
  input wire logic [7:0]           i_sfr_addr,
  input wire logic                 o_sfr_rdata_vld,
  input wire rscc_pkg::rscc_byte_t o_sfr_rdata,
  input wire logic                 o_chip_rst,
  input wire logic                 o_boot_app,
  input wire logic                 o_rc_osc_en
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  AST_HOLD: assert property ($fell(i_srst) |->
    o_chip_rst[*8] ##1 o_chip_rst[*8] ##1 !o_chip_rst)
    else $error("bad hold");
  AST_WARM: assert property ((i_pin_rst || i_wdt_rst || i_bor_rst)
    |=> o_chip_rst) else $error("no warm reset");
  // registered lag allowed before the oscillator drops
  AST_OSC: assert property (o_chip_rst[*3] |-> !o_rc_osc_en)
    else $error("osc on in reset");
  AST_TRIG: assert property (o_sfr_rdata_vld &&
    $past(i_sfr_addr) == `RSCC_ADDR_CHIP |-> !o_sfr_rdata[7])
    else $error("trigger readable");
  AST_RSV: assert property (o_sfr_rdata_vld &&
    $past(i_sfr_addr) == `RSCC_ADDR_CAUSE |-> (o_sfr_rdata & 8'hfa) == 8'h00)
    else $error("reserved bits set");
  AST_VLD: assert property (i_sfr_rd |=> o_sfr_rdata_vld)
    else $error("no read valid");
  AST_BOOT: assert property ($rose(o_boot_app) |-> ##[0:1] o_chip_rst)
    else $error("boot without reset");
  AST_BOOT_END: assert property ($fell(o_chip_rst)
    |-> ##[0:1] !o_boot_app) else $error("boot flag stuck");
  cover property ($rose(o_boot_app));
  cover property (i_bor_rst);
  cover property (o_rc_osc_en);
endmodule // rscc_chk

bind rscc_top rscc_chk chk_u (.i_mclk, .i_srst, .i_pin_rst, .i_wdt_rst,
  .i_bor_rst, .i_sfr_rd, .i_sfr_addr, .o_sfr_rdata_vld, .o_sfr_rdata,
  .o_chip_rst, .o_boot_app, .o_rc_osc_en);

/* File: bench/tb_rscc_top.sv */
/* self-checking bench of rscc_top.
   drives the sfr bus and reset requests itself. */
`timescale 1ns/1ns
`include "rscc_map.svh"
module tb_rscc_top;
  import rscc_pkg::*;
  logic       i_mclk, i_srst, i_pin_rst, i_wdt_rst, i_bor_rst, i_prog_fail;
  logic       i_sfr_wr, i_sfr_rd, o_sfr_rdata_vld, o_chip_rst, o_boot_app;
  logic       o_rc_osc_en;
  logic       o_boot_bank_select, o_ext_ram_enable, o_loader_update_enable;
  logic       o_baud_double, o_idle_request, o_power_down_request;
  logic [7:0] chip_outs, pwr_outs;
  logic [7:0] i_sfr_addr;
  rscc_byte_t i_sfr_wdata, o_sfr_rdata;
  int         failures, check_count, cyc;
  rscc_top dut_u (.i_mclk, .i_srst, .i_pin_rst, .i_wdt_rst, .i_bor_rst,
    .i_prog_fail, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd,
    .o_sfr_rdata_vld, .o_sfr_rdata, .o_chip_rst, .o_boot_app, .o_rc_osc_en,
    .o_boot_bank_select, .o_ext_ram_enable, .o_loader_update_enable,
    .o_baud_double, .o_idle_request, .o_power_down_request);
  // pin images of chip control and power control bit positions
  assign chip_outs = {2'h0, o_loader_update_enable, o_ext_ram_enable, 2'h0,
                      o_boot_bank_select, o_rc_osc_en};
  assign pwr_outs  = {o_baud_double, 5'h00, o_power_down_request,
                      o_idle_request};
  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input rscc_byte_t got, input rscc_byte_t exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe stays up so back-to-back cycles never reassign it in one step
  task wr(input logic [7:0] a, input rscc_byte_t d);
    i_sfr_rd    = 1'b0;
    i_sfr_wr    = 1'b1;
    i_sfr_addr  = a;
    i_sfr_wdata = d;
    @(posedge i_mclk);
    #1;
  endtask
  task rd(input logic [7:0] a, input rscc_byte_t e);
    i_sfr_wr   = 1'b0;
    i_sfr_rd   = 1'b1;
    i_sfr_addr = a;
    @(posedge i_mclk);
    #1;
    chk({7'h0, o_sfr_rdata_vld}, 8'h01);
    chk(o_sfr_rdata, e);
  endtask
  task run;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    while (o_chip_rst !== 1'b0) begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  task unlock;
    wr(`RSCC_ADDR_UNLOCK, `RSCC_UNLOCK_KEY1);
    wr(`RSCC_ADDR_UNLOCK, `RSCC_UNLOCK_KEY2);
  endtask
  task t_cold;
    run;
    rd(`RSCC_ADDR_CAUSE, 8'h00);
    rd(`RSCC_ADDR_PWR, 8'h10);
    rd(`RSCC_ADDR_CHIP, `RSCC_CH_RST);
    chk({7'h0, o_rc_osc_en}, 8'h00);
    rd(8'h90, 8'h00);
  endtask
  task t_isp;
    unlock;
    wr(`RSCC_ADDR_CHIP, 8'h00);
    rd(`RSCC_ADDR_CHIP, 8'h00);
    chk({7'h0, o_rc_osc_en}, 8'h01);
    wr(`RSCC_ADDR_CHIP, 8'h01);
    rd(`RSCC_ADDR_CHIP, 8'h00);
    unlock;
    wr(`RSCC_ADDR_CHIP, 8'h01);
    rd(`RSCC_ADDR_CHIP, 8'h01);
    chk({7'h0, o_rc_osc_en}, 8'h00);
  endtask
  task t_soft;
    i_prog_fail = 1'b1;
    rd(`RSCC_ADDR_CHIP, 8'h01);
    i_prog_fail = 1'b0;
    rd(`RSCC_ADDR_CHIP, 8'h41);
    unlock;
    wr(`RSCC_ADDR_CHIP, 8'h80);
    chk({6'h0, o_chip_rst, o_boot_app}, 8'h03);
    run;
    // the boot target is dropped one cycle after the hold ends
    @(posedge i_mclk);
    #1;
    chk({7'h0, o_boot_app}, 8'h00);
    rd(`RSCC_ADDR_CAUSE, 8'h01);
    rd(`RSCC_ADDR_PWR, 8'h10);
    rd(`RSCC_ADDR_CHIP, 8'h01);
  endtask
  task t_ctrl;
    unlock;
    wr(`RSCC_ADDR_CHIP, 8'h33);
    wr(`RSCC_ADDR_PWR, 8'h9f);
    rd(`RSCC_ADDR_CHIP, 8'h33);
    rd(`RSCC_ADDR_PWR, 8'h9f);
    chk(chip_outs, 8'h32);
    chk(pwr_outs, 8'h83);
  endtask
  task t_warm;
    i_bor_rst = 1'b1;
    rd(8'h90, 8'h00);
    i_bor_rst = 1'b0;
    run;
    chk(chip_outs, 8'h00);
    chk(pwr_outs, 8'h00);
    rd(`RSCC_ADDR_PWR, 8'h10);
    rd(`RSCC_ADDR_CAUSE, 8'h05);
    wr(`RSCC_ADDR_CAUSE, 8'hff);
    rd(`RSCC_ADDR_CAUSE, 8'h05);
    wr(`RSCC_ADDR_CAUSE, 8'h00);
    wr(`RSCC_ADDR_PWR, 8'h00);
    rd(`RSCC_ADDR_CAUSE, 8'h00);
    i_wdt_rst = 1'b1;
    i_pin_rst = 1'b1;
    rd(`RSCC_ADDR_PWR, 8'h00);
    i_wdt_rst = 1'b0;
    i_pin_rst = 1'b0;
    run;
    rd(`RSCC_ADDR_PWR, 8'h00);
    rd(`RSCC_ADDR_CAUSE, 8'h00);
  endtask
  // second power-on in mid-run: the cleared cold-boot flag comes back
  task t_power;
    {i_srst, i_sfr_wr, i_sfr_rd} = 3'h4;
    repeat (4) @(posedge i_mclk);
    #1;
    i_srst = 1'b0;
    run;
    rd(`RSCC_ADDR_PWR, 8'h10);
    rd(`RSCC_ADDR_CHIP, `RSCC_CH_RST);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    {i_srst, i_sfr_wr, i_sfr_rd} = 3'h4;
    {i_pin_rst, i_wdt_rst, i_bor_rst, i_prog_fail} = 4'h0;
    i_sfr_addr  = 8'h00;
    i_sfr_wdata = 8'h00;
    repeat (4) @(posedge i_mclk);
    #1;
    i_srst = 1'b0;
    t_cold;
    t_isp;
    t_soft;
    t_ctrl;
    t_warm;
    t_power;
    stop_test;
  end
endmodule // tb_rscc_top

/* File: hw/rscc_map.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * reset-cause and chip-control block.
 * assumes an 8-bit special-function-register bus with byte addresses.
 */
// What this block does
// R1: five reset sources: power-on, pin, software, watchdog, brown-out; each resets chip.
// R2: all registers take reset values on any reset, except the cause flags and the cold-boot flag.
// R3: brown-out reset sets brown-out flag, bit 2 of reset status.
// R4: software reset sets software-reset flag, bit 0 of reset status.
// R5: software should clear flags after reading; hardware clears them only on power-on reset.
// R6: completed power-on reset sets cold-boot flag, bit 4 of power control.
// R7: cold-boot flag keeps its value through every non-power-on reset.
// R8: programming enable bit 0 is inverted: 0 enables, 1 disables.
// R9: enabling programming starts the internal 22.1184 MHz RC oscillator.
// R10: software returns programming enable to disabled as its last step.
// R11: chip control is timed-access protected; bit 7 write-only, bits 6, 5, 4, 1 and 0 read/write.
// R12: unlocked write of bit 7 causes software reset, reboot from application memory.
// R13: writing 0 clears a cause flag; writing 1 leaves it unchanged.
`ifndef RSCC_MAP_SVH
`define RSCC_MAP_SVH

`define RSCC_ADDR_CAUSE    8'h96
`define RSCC_ADDR_CHIP     8'h9f
`define RSCC_ADDR_PWR      8'h87
`define RSCC_ADDR_UNLOCK   8'hc7

`define RSCC_UNLOCK_KEY1   8'haa
`define RSCC_UNLOCK_KEY2   8'h55

`define RSCC_CAUSE_BOR     2
`define RSCC_CAUSE_SW      0
`define RSCC_CAUSE_MASK    8'h05

`define RSCC_CH_TRIG       7
`define RSCC_CH_PFAIL      6
`define RSCC_CH_LDU        5
`define RSCC_CH_XRAM       4
`define RSCC_CH_BANK       1
`define RSCC_CH_PEN        0
`define RSCC_CH_RW_MASK    8'h73
`define RSCC_CH_RST        8'h01

`define RSCC_PC_BAUD       7
`define RSCC_PC_COLD       4
`define RSCC_PC_PDOWN      1
`define RSCC_PC_IDLE       0
`define RSCC_PC_RW_MASK    8'h8f
`define RSCC_PC_RST        8'h00

`define RSCC_CLK_HZ        20000000
`define RSCC_RC_OSC_HZ     22118400
`define RSCC_HOLD_CYC      16
`define RSCC_UNLOCK_WIN_CYC 3

`endif

/* File: hw/rscc_pkg.sv */
/*
 * types of the reset-cause and chip-control block.
 * assumes rscc_map.svh for all numeric constants.
 */
package rscc_pkg;

  typedef logic [7:0] rscc_byte_t;

  typedef enum logic [1:0] {
    RSCC_ST_RUN  = 2'b01,
    RSCC_ST_HOLD = 2'b10
  } rscc_state_t;

endpackage

/* File: hw/rscc_top.sv */
/*
 * reset sequencer with reset-cause flags, power control and the
 * timed-access protected chip control register.
 * assumes a synchronous special-function-register bus on i_mclk and reset
 * requests from detectors that are already synchronous; i_srst is the
 * power-on reset.
 */
`timescale 1ns/1ns
`include "rscc_map.svh"

module rscc_top (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_pin_rst,
  input  wire logic             i_wdt_rst,
  input  wire logic             i_bor_rst,
  input  wire logic             i_prog_fail,
  input  wire logic [7:0]       i_sfr_addr,
  input  wire rscc_pkg::rscc_byte_t i_sfr_wdata,
  input  wire logic             i_sfr_wr,
  input  wire logic             i_sfr_rd,
  output logic                  o_sfr_rdata_vld,
  output rscc_pkg::rscc_byte_t  o_sfr_rdata,
  output logic                  o_chip_rst,
  output logic                  o_boot_app,
  output logic                  o_rc_osc_en,
  output logic                  o_boot_bank_select,
  output logic                  o_ext_ram_enable,
  output logic                  o_loader_update_enable,
  output logic                  o_baud_double,
  output logic                  o_idle_request,
  output logic                  o_power_down_request
);
  import rscc_pkg::*;

  localparam logic [4:0] HOLD_CYC = 5'(`RSCC_HOLD_CYC);
  localparam logic [1:0] UNLOCK_WIN = 2'(`RSCC_UNLOCK_WIN_CYC);

  function automatic logic sfr_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    sfr_hit = (a == off);
  endfunction

  rscc_state_t state_q;
  logic [4:0]  hold_cnt_q;
  logic        key1_q;
  logic [1:0]  unlock_win_q;
  logic        bor_flag_q;
  logic        sw_flag_q;
  logic        cold_q;
  rscc_byte_t  chip_q;
  rscc_byte_t  pwr_q;
  rscc_byte_t  rdata_q;
  logic        rvld_q;
  logic        boot_app_q;

  logic wr_en;
  logic wr_cause;
  logic wr_chip;
  logic wr_pwr;
  logic wr_unlock;
  logic unlock_open;
  logic sw_rst_req;
  logic any_warm;

  // the cpu is held in reset while o_chip_rst is high, so writes then are void
  assign wr_en       = i_sfr_wr && (state_q == RSCC_ST_RUN);
  assign wr_cause    = wr_en && sfr_hit(i_sfr_addr, `RSCC_ADDR_CAUSE);
  assign wr_chip     = wr_en && sfr_hit(i_sfr_addr, `RSCC_ADDR_CHIP);
  assign wr_pwr      = wr_en && sfr_hit(i_sfr_addr, `RSCC_ADDR_PWR);
  assign wr_unlock   = wr_en && sfr_hit(i_sfr_addr, `RSCC_ADDR_UNLOCK);
  assign unlock_open = (unlock_win_q != 2'h0);
  assign sw_rst_req  = wr_chip && unlock_open &&
                       i_sfr_wdata[`RSCC_CH_TRIG]; // R12
  // pin, watchdog and brown-out requests are honoured even mid-hold
  assign any_warm = i_pin_rst || i_wdt_rst || i_bor_rst || sw_rst_req; // R1

  // reset sequencer: every source stretches into one chip-wide reset pulse
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q    <= RSCC_ST_HOLD;
      hold_cnt_q <= HOLD_CYC;
    end else if (any_warm) begin
      state_q    <= RSCC_ST_HOLD; // R1
      hold_cnt_q <= HOLD_CYC;
    end else begin
      case (state_q)
        RSCC_ST_RUN: begin
          hold_cnt_q <= 5'h00;
        end
        RSCC_ST_HOLD: begin
          if (hold_cnt_q == 5'h01) begin
            state_q <= RSCC_ST_RUN;
          end
          hold_cnt_q <= hold_cnt_q - 5'h01;
        end
        default: begin
          state_q    <= RSCC_ST_HOLD;
          hold_cnt_q <= HOLD_CYC;
        end
      endcase
    end
  end

  // software reset reboots from application memory: flag the boot target
  always_ff @(posedge i_mclk) begin
    if (i_srst || i_pin_rst || i_wdt_rst || i_bor_rst) begin
      boot_app_q <= 1'b0;
    end else if (sw_rst_req) begin
      boot_app_q <= 1'b1; // R12
    end else if (state_q == RSCC_ST_RUN) begin
      boot_app_q <= 1'b0;
    end
  end

  // timed access: key1 then key2 opens a short window for one write
  // key1 is kept until the next unlock write, so bus traffic to other
  // registers between the two keys does not spoil the sequence
  always_ff @(posedge i_mclk) begin
    if (i_srst || any_warm) begin
      key1_q       <= 1'b0;
      unlock_win_q <= 2'h0;
    end else if (wr_unlock) begin
      key1_q <= (i_sfr_wdata == `RSCC_UNLOCK_KEY1) && !key1_q;
      if (key1_q && (i_sfr_wdata == `RSCC_UNLOCK_KEY2)) begin
        unlock_win_q <= UNLOCK_WIN; // R11
      end else begin
        unlock_win_q <= 2'h0;
      end
    end else if (wr_chip) begin
      unlock_win_q <= 2'h0; // R11
    end else if (unlock_open) begin
      unlock_win_q <= unlock_win_q - 2'h1;
    end
  end

  // cause flags survive warm resets; a set in the clearing cycle wins
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bor_flag_q <= 1'b0;
      sw_flag_q  <= 1'b0;
    end else begin
      if (i_bor_rst) begin
        bor_flag_q <= 1'b1; // R3
      end else if (wr_cause) begin
        bor_flag_q <= bor_flag_q & i_sfr_wdata[`RSCC_CAUSE_BOR]; // R13
      end
      if (sw_rst_req) begin
        sw_flag_q <= 1'b1; // R4
      end else if (wr_cause) begin
        sw_flag_q <= sw_flag_q & i_sfr_wdata[`RSCC_CAUSE_SW]; // R13
      end
    end
  end

  // cold-boot flag: only power-on sets it, nothing but software clears it
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cold_q <= 1'b1; // R6
    end else if (wr_pwr) begin
      cold_q <= cold_q & i_sfr_wdata[`RSCC_PC_COLD]; // R7 R13
    end
  end

  // chip control: protected, and reset to programming disabled
  always_ff @(posedge i_mclk) begin
    if (i_srst || any_warm) begin
      chip_q <= `RSCC_CH_RST; // R2
    end else begin
      if (wr_chip && unlock_open) begin
        chip_q <= i_sfr_wdata & `RSCC_CH_RW_MASK; // R11
      end
      // a fail pulse in the cycle of a write still sets the flag
      if (i_prog_fail) begin
        chip_q[`RSCC_CH_PFAIL] <= 1'b1;
      end
    end
  end

  // power control: plain read/write bits, reset by any source
  always_ff @(posedge i_mclk) begin
    if (i_srst || any_warm) begin
      pwr_q <= `RSCC_PC_RST; // R2
    end else if (wr_pwr) begin
      pwr_q <= i_sfr_wdata & `RSCC_PC_RW_MASK;
    end
  end

  // registered read answer, one cycle after i_sfr_rd
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
      rvld_q  <= 1'b0;
    end else begin
      rvld_q <= i_sfr_rd;
      if (!i_sfr_rd) begin
        rdata_q <= rdata_q;
      end else if (sfr_hit(i_sfr_addr, `RSCC_ADDR_CAUSE)) begin
        rdata_q <= {5'h00, bor_flag_q, 1'b0, sw_flag_q};
      end else if (sfr_hit(i_sfr_addr, `RSCC_ADDR_CHIP)) begin
        rdata_q <= chip_q & `RSCC_CH_RW_MASK; // R11
      end else if (sfr_hit(i_sfr_addr, `RSCC_ADDR_PWR)) begin
        rdata_q <= {pwr_q[7:5], cold_q, pwr_q[3:0]};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign o_sfr_rdata_vld        = rvld_q;
  assign o_sfr_rdata            = rdata_q;
  assign o_chip_rst             = (state_q != RSCC_ST_RUN); // R1
  assign o_boot_app             = boot_app_q;
  // inverted enable; oscillator runs only while programming is enabled
  assign o_rc_osc_en            = !chip_q[`RSCC_CH_PEN]; // R8 R9
  assign o_boot_bank_select     = chip_q[`RSCC_CH_BANK];
  assign o_ext_ram_enable       = chip_q[`RSCC_CH_XRAM];
  assign o_loader_update_enable = chip_q[`RSCC_CH_LDU];
  assign o_baud_double          = pwr_q[`RSCC_PC_BAUD];
  assign o_idle_request         = pwr_q[`RSCC_PC_IDLE];
  assign o_power_down_request   = pwr_q[`RSCC_PC_PDOWN];

endmodule // rscc_top
